// ===== tb/shc_codec_tb.sv
// Self-checking bench of the stacking header codec: insertion in every forward mode,
// stripping of good, bad, short and unstripped frames.
// Assumes the far-side model shc_np_model and a 125 MHz core clock.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
   n_compared++; \
   if ((g) !== (e)) begin \
      bad_count++; \
      $display("mismatch %s exp %h got %h", nm, e, g); \
   end \
end
module shc_codec_tb;
   import shc_pkg::*;
   localparam logic [15:0] TYPE_WORD = 16'h5A3C; // Arbitrary value
   int bad_count = 0, n_compared = 0, hv_cnt = 0, err_cnt = 0, cycles = 0, k;
   logic clock = 1'b0, rst = 1'b1, stall = 1'b0, to_core_ready = 1'b0;
   logic insert_enable = 1'b0, strip_enable = 1'b0, misc_service_index_enable = 1'b0;
   logic super_priority_flag = 1'b0, ingress_congestion_mode = 1'b0, learning_select = 1'b0;
   logic destination_port_type = 1'b0, ttl_keep = 1'b0;
   logic [1:0] drop_precedence_level = 2'h0, core_slow = 2'h0;
   logic [2:0] class_of_service_id = 3'h0, classified_internal_priority = 3'h0;
   logic [3:0] aggregation_code = 4'h0;
   logic [4:0] time_to_live = 5'h0, destination_unit = 5'h0, destination_port_number = 5'h0;
   logic [9:0] group_index = 10'h0;
   logic [10:0] rewrite_command = 11'h0;
   logic [11:0] ingress_service_index = 12'h0;
   logic [31:0] tag_source_section = 32'h0;
   shc_forward_type forward_select = shc_fwd_local_lookup;
   logic [7:0] from_core_data = 8'h00, to_port_data, from_port_data, to_core_data;
   logic from_core_valid = 1'b0, from_core_last = 1'b0, from_core_ready, to_port_valid, to_port_last;
   logic to_port_ready, from_port_valid, from_port_last, from_port_ready, to_core_valid, to_core_last;
   logic rx_header_valid, rx_super_priority, rx_frame_error;
   logic [79:0] rx_header;
   logic [8:0] core_q[$];
   ////////////////////////////////////////////////////////////////////////////
   shc_codec #(.STACK_TYPE_WORD(TYPE_WORD)) DUT (.clock, .rst, .insert_enable, .strip_enable,
      .misc_service_index_enable, .class_of_service_id, .ingress_service_index, .aggregation_code,
      .drop_precedence_level, .super_priority_flag, .classified_internal_priority, .ingress_congestion_mode,
      .time_to_live, .learning_select, .forward_select, .rewrite_command, .destination_port_type,
      .destination_unit, .destination_port_number, .group_index, .ttl_keep, .tag_source_section,
      .from_core_data, .from_core_valid, .from_core_last, .from_core_ready, .to_port_data, .to_port_valid,
      .to_port_last, .to_port_ready, .from_port_data, .from_port_valid, .from_port_last, .from_port_ready,
      .to_core_data, .to_core_valid, .to_core_last, .to_core_ready, .rx_header, .rx_header_valid,
      .rx_super_priority, .rx_frame_error);
   shc_np_model model (.clock, .rst, .stall, .to_port_data, .to_port_valid, .to_port_last, .to_port_ready,
      .from_port_data, .from_port_valid, .from_port_last, .from_port_ready);
   always #4 clock = ~clock;
   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (bad_count == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   always @(posedge clock) begin
      cycles++;
      if (to_core_valid === 1'b1 && to_core_ready)
         core_q.push_back({to_core_last, to_core_data});
      hv_cnt += int'(rx_header_valid === 1'b1);
      err_cnt += int'(rx_frame_error === 1'b1);
      core_slow <= core_slow + 2'h1;
      to_core_ready <= !rst && (!stall || core_slow == 2'h3);
      if (cycles == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [79:0] exp_hdr();
      logic [79:0] h;
      h = 80'h0;
      // lead bit set, reserved bits left zero
      h[79] = 1'b1;
      if (misc_service_index_enable)
         h[78:64] = {class_of_service_id, ingress_service_index};
      else
         h[67:64] = aggregation_code;
      h[61:55] = {drop_precedence_level, super_priority_flag, classified_internal_priority, ingress_congestion_mode};
      h[52:44] = {time_to_live, learning_select, forward_select};
      case (forward_select)
         shc_fwd_local_lookup, shc_fwd_global_mirror: h[42:32] = rewrite_command;
         shc_forward_logical_port_port: h[42:32] = {destination_port_type, destination_unit, destination_port_number};
         shc_forward_physical_port_port: h[41:32] = {destination_unit, destination_port_number};
         shc_fwd_group: h[41:32] = group_index;
         shc_fwd_unit_processor: h[41:32] = {destination_unit, 1'b0, destination_port_number[3:0]};
         shc_fwd_all_processors: h[41:32] = {ttl_keep, 5'h00, destination_port_number[3:0]};
         default: h[42:32] = 11'h000;
      endcase
      h[31:0] = tag_source_section;
      return h;
   endfunction : exp_hdr
   task automatic set_fields(input logic [2:0] f);
      logic [31:0] p;
      // All ones in some modes shows whether reserved positions are forced to zero
      p = (f[1] || f == 3'h5) ? 32'hFFFFFFFF : 32'hA5A5A5A5;
      misc_service_index_enable <= f[0];
      forward_select <= shc_forward_type'(f);
      class_of_service_id <= p[2:0];
      ingress_service_index <= p[11:0];
      aggregation_code <= p[3:0];
      drop_precedence_level <= p[1:0];
      super_priority_flag <= p[6];
      classified_internal_priority <= p[2:0];
      ingress_congestion_mode <= p[1];
      time_to_live <= p[4:0];
      learning_select <= p[2];
      rewrite_command <= p[10:0];
      destination_port_type <= p[0];
      destination_unit <= p[6:2];
      destination_port_number <= p[4:0];
      group_index <= p[9:0];
      ttl_keep <= p[3];
      tag_source_section <= p ^ {29'h0, f};
      @(posedge clock);
   endtask : set_fields
   task automatic core_byte(input logic [7:0] d, input logic l);
      int t;
      from_core_data <= d;
      from_core_valid <= 1'b1;
      from_core_last <= l;
      t = 0;
      do begin
         @(posedge clock);
         t++;
      end while (from_core_ready !== 1'b1 && t < 300);
      if (l)
         from_core_valid <= 1'b0;
   endtask : core_byte
   ////////////////////////////////////////////////////////////////////////////
   task automatic ins_frame(input logic [2:0] f, input logic en);
      logic [79:0] h;
      logic [8:0] e;
      int i, t, n;
      insert_enable <= en;
      stall <= f[0];
      set_fields(f);
      h = exp_hdr();
      n = en ? 14 : 2;
      model.rx_q.delete();
      core_byte(8'h11, 1'b0);
      core_byte(8'h22, 1'b1);
      for (t = 0; t < 300 && model.rx_q.size() < n; t++)
         @(posedge clock);
      repeat (4) @(posedge clock);
      `CHK("insert count", n, model.rx_q.size())
      for (i = 14 - n; i < 14 && i - 14 + n < model.rx_q.size(); i++) begin
         e[8] = (i == 13);
         e[7:0] = i < 2 ? TYPE_WORD[15 - 8 * i -: 8] : i < 12 ? h[79 - 8 * (i - 2) -: 8] : (i == 12 ? 8'h11 : 8'h22);
         `CHK("insert byte", e, model.rx_q[i - 14 + n])
      end
   endtask : ins_frame
   task automatic str_frame(input logic [2:0] k);
      logic [79:0] h;
      logic [8:0] s[$];
      int i, t, hv0, er0, nb;
      strip_enable <= (k != 3'h6);
      stall <= k[0];
      set_fields(k[0] ? 3'h3 : 3'h4);
      h = exp_hdr();
      if (k == 3'h2)
         h[79] = 1'b0;
      if (k == 3'h3)
         h[46:44] = 3'h7;
      s.push_back({1'b0, TYPE_WORD[15:8] ^ {8{k == 3'h4}}});
      s.push_back({1'b0, TYPE_WORD[7:0]});
      // Short frame ends at its seventh byte, so nothing of it follows the last flag
      for (i = 0; i < (k == 3'h5 ? 5 : 10); i++)
         s.push_back({k == 3'h5 && i == 4, h[79 - 8 * i -: 8]});
      if (k != 3'h5)
         for (i = 0; i < 3; i++)
            s.push_back({i == 2, 8'hB0 + i[7:0]});
      nb = k == 3'h6 ? 15 : k < 3'h2 ? 3 : 0;
      hv0 = hv_cnt;
      er0 = err_cnt;
      core_q.delete();
      for (i = 0; i < s.size(); i++)
         model.tx_q.push_back(s[i]);
      for (t = 0; t < 300 && (model.tx_q.size() > 0 || core_q.size() < nb); t++)
         @(posedge clock);
      repeat (20) @(posedge clock);
      `CHK("good headers", int'(k < 3'h2), hv_cnt - hv0)
      `CHK("frame errors", int'(k > 3'h1 && k < 3'h6), err_cnt - er0)
      `CHK("core count", nb, core_q.size())
      if (k < 3'h2) begin
         `CHK("rx header", h, rx_header)
         `CHK("super priority", h[59], rx_super_priority)
      end
      for (i = 0; i < nb && i < core_q.size(); i++)
         `CHK("core byte", s[i + 15 - nb], core_q[i])
   endtask : str_frame
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      for (k = 0; k < 8; k++)
         ins_frame(k[2:0], 1'b1);
      ins_frame(3'h0, 1'b0);
      for (k = 0; k < 7; k++)
         str_frame(k[2:0]);
      tally_and_finish();
   end
endmodule : shc_codec_tb

// ===== tb/shc_np_model.sv
// Far-side model of the node processor port: sinks inserted frames, sources frames to strip.
// Assumes the codec byte streams with valid/ready/last on one rising-edge clock.
`timescale 1ns/1ns
module shc_np_model (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       stall,
   input  wire logic [7:0] to_port_data,
   input  wire logic       to_port_valid,
   input  wire logic       to_port_last,
   output logic            to_port_ready,
   output logic [7:0]      from_port_data,
   output logic            from_port_valid,
   output logic            from_port_last,
   input  wire logic       from_port_ready
);
   logic [8:0] tx_q[$];
   logic [8:0] rx_q[$];
   logic [1:0] slow;
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clock) begin
      if (rst) begin
         to_port_ready <= 1'b0;
         from_port_valid <= 1'b0;
         from_port_last <= 1'b0;
         from_port_data <= 8'h00;
         slow <= 2'h0;
      end else begin
         if (to_port_valid === 1'b1 && to_port_ready)
            rx_q.push_back({to_port_last, to_port_data});
         // One accept in four while stalling, so the codec buffer fills up
         slow <= slow + 2'h1;
         to_port_ready <= !stall || slow == 2'h3;
         if (from_port_valid && from_port_ready === 1'b1)
            void'(tx_q.pop_front());
         if (tx_q.size() > 0) begin
            from_port_valid <= 1'b1;
            from_port_data <= tx_q[0][7:0];
            from_port_last <= tx_q[0][8];
         end else begin
            // Released data toggles so a stale byte is never mistaken for a good one
            from_port_valid <= 1'b0;
            from_port_data <= ~from_port_data;
            from_port_last <= 1'b0;
         end
      end
   end
endmodule : shc_np_model

// ===== verilog/shc_codec.sv
// Stacking header codec for the node processor port: inserts the 12-byte
// header into frames leaving the core and strips and checks it on entry.
// Assumes byte streams with valid/ready/last, all on the core clock.
//
// Summary of operation
// - Header is 2-byte type word plus 10-byte field payload, 12 bytes.
// - Header insertion and stripping enabled per port by an option.
// - Bit 79 set on insertion and checked on every stripped frame.
// - Misc bits hold class and service index, or aggregation code, by setting.
// - Bits 63:62, 54, 53 and 43 are always zero.
// - Two-bit drop precedence level sits in bits 61:60.
// - Bit 59 marks super-priority frames, steered to dedicated queues.
// - Bits 58:56 carry the classified internal priority.
// - Bit 55 gives ingress congestion mode: flow control or drop.
// - Bits 52:48 time to live; bit 47 set skips learning.
// - Bits 46:44 forward mode, seven codes, code 7 reserved.
// - Local lookup and global mirror carry rewrite command in 42:32.
// - Logical port: port type, unit set, logical port number.
// - Physical port: zero, unit set, physical port number.
// - Group mode carries group index in bits 41:32.
// - Unit processor: bits 42, 36 zero, unit set, 4-bit port.
// - All processors: bit 41 keep-ttl, others zero, 4-bit port.
`timescale 1ns/1ns
`include "shc_regs.svh"
module shc_codec #(
   parameter logic [15:0] STACK_TYPE_WORD = 16'hA5C3 // Arbitrary value
) (
   input  wire logic                     clock,
   input  wire logic                     rst,
   input  wire logic                     insert_enable,
   input  wire logic                     strip_enable,
   input  wire logic                     misc_service_index_enable,
   input  wire logic [2:0]               class_of_service_id,
   input  wire logic [11:0]              ingress_service_index,
   input  wire logic [3:0]               aggregation_code,
   input  wire logic [1:0]               drop_precedence_level,
   input  wire logic                     super_priority_flag,
   input  wire logic [2:0]               classified_internal_priority,
   input  wire logic                     ingress_congestion_mode,
   input  wire logic [4:0]               time_to_live,
   input  wire logic                     learning_select,
   input  wire shc_pkg::shc_forward_type forward_select,
   input  wire logic [10:0]              rewrite_command,
   input  wire logic                     destination_port_type,
   input  wire logic [4:0]               destination_unit,
   input  wire logic [4:0]               destination_port_number,
   input  wire logic [9:0]               group_index,
   input  wire logic                     ttl_keep,
   input  wire logic [31:0]              tag_source_section,
   input  wire logic [7:0]               from_core_data,
   input  wire logic                     from_core_valid,
   input  wire logic                     from_core_last,
   output logic                          from_core_ready,
   output logic [7:0]                    to_port_data,
   output logic                          to_port_valid,
   output logic                          to_port_last,
   input  wire logic                     to_port_ready,
   input  wire logic [7:0]               from_port_data,
   input  wire logic                     from_port_valid,
   input  wire logic                     from_port_last,
   output logic                          from_port_ready,
   output logic [7:0]                    to_core_data,
   output logic                          to_core_valid,
   output logic                          to_core_last,
   input  wire logic                     to_core_ready,
   output logic [79:0]                   rx_header,
   output logic                          rx_header_valid,
   output logic                          rx_super_priority,
   output logic                          rx_frame_error
);
   import shc_pkg::*;

   typedef struct packed {
      shc_ins_state_type ins_state;
      logic [3:0]        ins_count;
      logic [95:0]       ins_shift;
      shc_par_state_type par_state;
      logic [3:0]        par_count;
      logic [95:0]       par_shift;
      logic [79:0]       header;
      logic              header_valid;
      logic              super_priority;
      logic              frame_error;
      logic [1:0][8:0]   a_mem;
      logic [1:0]        a_count;
      logic              a_wr;
      logic              a_rd;
      logic [1:0][8:0]   b_mem;
      logic [1:0]        b_count;
      logic              b_wr;
      logic              b_rd;
   } shc_state_type;

   shc_state_type r;
   shc_state_type next_r;
   logic [79:0]   built;
   logic [10:0]   dest;
   logic          a_push;
   logic          a_pop;
   logic [8:0]    a_word;
   logic          b_push;
   logic          b_pop;
   logic          bad_header;
   logic [95:0]   par_next_shift;

   ////////////////////////////////////////////////////////////////////////////
   // Header assembly from the field inputs
   always_comb begin
      case (forward_select)
         shc_fwd_local_lookup, shc_fwd_global_mirror: dest = rewrite_command;
         shc_forward_logical_port_port: dest = {destination_port_type, destination_unit, destination_port_number};
         shc_forward_physical_port_port: dest = {1'b0, destination_unit, destination_port_number};
         shc_fwd_group: dest = {1'b0, group_index};
         shc_fwd_unit_processor: dest = {1'b0, destination_unit, 1'b0, destination_port_number[3:0]};
         shc_fwd_all_processors: dest = {1'b0, ttl_keep, 5'h00, destination_port_number[3:0]};
         default: dest = 11'h000;
      endcase
   end

   assign built = {1'b1,
                   misc_service_index_enable ? {class_of_service_id, ingress_service_index}
                                             : {11'h000, aggregation_code},
                   2'h0, drop_precedence_level, super_priority_flag,
                   classified_internal_priority, ingress_congestion_mode, 2'h0,
                   time_to_live, learning_select, forward_select, 1'b0, dest,
                   tag_source_section};

   ////////////////////////////////////////////////////////////////////////////
   // Buffer ports; combinational handshakes, data from flip-flops
   assign to_port_valid   = r.a_count != 2'h0;
   assign {to_port_last, to_port_data} = r.a_mem[r.a_rd];
   assign to_core_valid   = r.b_count != 2'h0;
   assign {to_core_last, to_core_data} = r.b_mem[r.b_rd];
   assign a_pop           = to_port_valid && to_port_ready;
   assign b_pop           = to_core_valid && to_core_ready;
   assign from_core_ready = (r.ins_state == ins_body) && (r.a_count != 2'h2);
   assign from_port_ready = (r.par_state == par_head) || (r.par_state == par_drop)
                            || ((r.par_state == par_body) && (r.b_count != 2'h2));
   assign rx_header         = r.header;
   assign rx_header_valid   = r.header_valid;
   assign rx_super_priority = r.super_priority;
   assign rx_frame_error    = r.frame_error;

   assign par_next_shift = {r.par_shift[87:0], from_port_data};
   assign bad_header = (par_next_shift[95:80] != STACK_TYPE_WORD)
                       || !par_next_shift[`SHC_LEAD_BIT]
                       || (par_next_shift[`SHC_FWD_HI:`SHC_FWD_LO] == shc_fwd_reserved);

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      next_r              = r;
      next_r.header_valid = 1'b0;
      next_r.frame_error  = 1'b0;
      a_push              = 1'b0;
      a_word              = {from_core_last, from_core_data};
      b_push              = 1'b0;

      case (r.ins_state)
         ins_idle: begin
            if (from_core_valid) begin
               if (insert_enable) begin
                  next_r.ins_shift = {STACK_TYPE_WORD, built};
                  next_r.ins_count = 4'h0;
                  next_r.ins_state = ins_head;
               end else begin
                  next_r.ins_state = ins_body;
               end
            end
         end
         ins_head: begin
            if (r.a_count != 2'h2) begin
               a_push           = 1'b1;
               a_word           = {1'b0, r.ins_shift[95:88]};
               next_r.ins_shift = {r.ins_shift[87:0], 8'h00};
               next_r.ins_count = r.ins_count + 4'h1;
               if (r.ins_count == `SHC_LAST_HDR_COUNT) begin
                  next_r.ins_state = ins_body;
               end
            end
         end
         ins_body: begin
            if (from_core_valid && from_core_ready) begin
               a_push = 1'b1;
               if (from_core_last) begin
                  next_r.ins_state = ins_idle;
               end
            end
         end
         default: next_r.ins_state = ins_idle;
      endcase

      case (r.par_state)
         par_idle: begin
            if (from_port_valid) begin
               next_r.par_count = 4'h0;
               next_r.par_state = strip_enable ? par_head : par_body;
            end
         end
         par_head: begin
            if (from_port_valid) begin
               next_r.par_shift = par_next_shift;
               next_r.par_count = r.par_count + 4'h1;
               if (from_port_last) begin
                  // Frame no longer than a header cannot be trusted
                  next_r.frame_error = 1'b1;
                  next_r.par_state   = par_idle;
               end else if (r.par_count == `SHC_LAST_HDR_COUNT) begin
                  if (bad_header) begin
                     next_r.frame_error = 1'b1;
                     next_r.par_state   = par_drop;
                  end else begin
                     next_r.header         = par_next_shift[79:0];
                     next_r.header_valid   = 1'b1;
                     next_r.super_priority = par_next_shift[`SHC_SP_BIT];
                     next_r.par_state      = par_body;
                  end
               end
            end
         end
         par_body: begin
            if (from_port_valid && from_port_ready) begin
               b_push = 1'b1;
               if (from_port_last) begin
                  next_r.par_state = par_idle;
               end
            end
         end
         par_drop: begin
            if (from_port_valid && from_port_last) begin
               next_r.par_state = par_idle;
            end
         end
         default: next_r.par_state = par_idle;
      endcase

      // Two-entry buffers: a stall downstream only backs up, never drops
      if (a_push) begin
         next_r.a_mem[r.a_wr] = a_word;
         next_r.a_wr          = ~r.a_wr;
      end
      if (a_pop) begin
         next_r.a_rd = ~r.a_rd;
      end
      next_r.a_count = r.a_count + {1'b0, a_push} - {1'b0, a_pop};
      if (b_push) begin
         next_r.b_mem[r.b_wr] = {from_port_last, from_port_data};
         next_r.b_wr          = ~r.b_wr;
      end
      if (b_pop) begin
         next_r.b_rd = ~r.b_rd;
      end
      next_r.b_count = r.b_count + {1'b0, b_push} - {1'b0, b_pop};
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         r           <= '0;
         r.ins_state <= ins_idle;
         r.par_state <= par_idle;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   // Header length is tracked per pushed byte, since a full buffer may hold the head state for many cycles
   hdr_start_a: assert property (
      (r.ins_state == ins_idle && from_core_valid && insert_enable)
      |=> r.ins_state == ins_head && r.ins_count == 4'h0)
      else $error("header does not start at byte zero");
   hdr_length_a: assert property (
      (r.ins_state == ins_head && r.a_count != 2'h2)
      |=> r.ins_count == $past(r.ins_count) + 4'h1
          && ((r.ins_state == ins_body) == ($past(r.ins_count) == `SHC_LAST_HDR_COUNT)))
      else $error("header length not twelve bytes");
   insert_bypass_a: assert property (
      (r.ins_state == ins_idle && from_core_valid && !insert_enable) |=> r.ins_state == ins_body)
      else $error("insertion happened while disabled");
   lead_bit_a: assert property (
      (r.ins_state == ins_idle && from_core_valid && insert_enable)
      |=> r.ins_shift[95:80] == STACK_TYPE_WORD && r.ins_shift[`SHC_LEAD_BIT])
      else $error("type word or lead bit wrong");
   misc_layout_a: assert property (
      (r.ins_state == ins_idle && from_core_valid && insert_enable && !misc_service_index_enable)
      |=> r.ins_shift[`SHC_MISC_RSV_HI:`SHC_MISC_RSV_LO] == 11'h000
          && r.ins_shift[67:64] == $past(aggregation_code))
      else $error("misc layout wrong");
   reserved_zero_a: assert property (
      (r.ins_state == ins_idle && from_core_valid && insert_enable)
      |=> r.ins_shift[63:62] == 2'h0 && !r.ins_shift[54] && !r.ins_shift[53] && !r.ins_shift[43])
      else $error("reserved header bit set");
   unit_proc_a: assert property (
      (r.ins_state == ins_idle && from_core_valid && insert_enable
       && forward_select == shc_fwd_unit_processor)
      |=> !r.ins_shift[42] && !r.ins_shift[36] && r.ins_shift[41:37] == $past(destination_unit))
      else $error("unit processor layout wrong");
   parse_error_a: assert property (
      (r.par_state == par_head && from_port_valid && !from_port_last
       && r.par_count == 4'hB && bad_header)
      |=> rx_frame_error && r.par_state == par_drop && !rx_header_valid)
      else $error("bad header not flagged");
   drop_silent_a: assert property (
      r.par_state == par_drop |=> $stable(r.b_wr))
      else $error("dropped frame reached the core");
   sp_steer_a: assert property (
      rx_header_valid |-> rx_super_priority == rx_header[`SHC_SP_BIT] && rx_header[`SHC_LEAD_BIT])
      else $error("super priority output mismatch");
   buffer_full_a: assert property (
      r.a_count == 2'h2 && !to_port_ready |=> $stable(r.a_wr) && to_port_valid)
      else $error("full buffer overwritten");

   insert_frame_c: cover property (r.ins_state == ins_head ##1 r.ins_state == ins_body [*2]);
   strip_ok_c:     cover property (rx_header_valid);
   strip_bad_c:    cover property (rx_frame_error);
   stall_full_c:   cover property (r.a_count == 2'h2 && !to_port_ready);
endmodule : shc_codec

// ===== verilog/shc_pkg.sv
// Types of the stacking header codec.
// Assumes nothing of its surroundings.
package shc_pkg;
   typedef enum logic [2:0] {
      shc_fwd_local_lookup   = 3'h0,
      shc_forward_logical_port_port   = 3'h1,
      shc_forward_physical_port_port  = 3'h2,
      shc_fwd_group          = 3'h3,
      shc_fwd_global_mirror  = 3'h4,
      shc_fwd_unit_processor = 3'h5,
      shc_fwd_all_processors = 3'h6,
      shc_fwd_reserved       = 3'h7
   } shc_forward_type;
   typedef enum logic [1:0] {ins_idle, ins_head, ins_body} shc_ins_state_type;
   typedef enum logic [1:0] {par_idle, par_head, par_body, par_drop} shc_par_state_type;
endpackage : shc_pkg

// ===== verilog/shc_regs.svh
// Field positions and counts of the stacking header codec.
// Assumes byte-wide streams and header bits sent most significant first.
`ifndef SHC_REGS_SVH
`define SHC_REGS_SVH
`define SHC_HEADER_BYTES   4'hC
`define SHC_LAST_HDR_COUNT 4'hB
`define SHC_LEAD_BIT       79
`define SHC_FWD_HI         46
`define SHC_FWD_LO         44
`define SHC_SP_BIT         59
`define SHC_MISC_RSV_HI    78
`define SHC_MISC_RSV_LO    68
`endif
